// ### dv/asm_alarm_checker.sv
// checker: port assertions of the alarm aggregator
`timescale 1ns/1ps
module asm_alarm_checker
  import asm_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        soft_reset_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        pll_locked_in,
  input wire logic        sysref_realign_in,
  input wire logic        divider_mismatch_in,
  input wire logic        cal_status_in,
  input wire logic        status_output_pin_out,
  input wire logic        irq_out
);
  // ****
  // shadow of mask and pin select, so irq and pin can be judged
  // ****
  logic [7:0] mask_q;
  logic       sel_q;
  wire        rst_ok = rst_n_in && !soft_reset_in;
  wire        rd_flags = rd_in && addr_in == ASM_FLAGS_ADDR;
  always_ff @(posedge clk_in)
  begin
    if (!rst_ok)
      {mask_q, sel_q} <= {8'h3F, 1'b0};
    else if (wr_in && addr_in == ASM_MASK_ADDR)
      mask_q <= wdata_in;
    else if (wr_in && addr_in == ASM_CTRL_ADDR)
      sel_q <= wdata_in[2];
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_ok);
  chk_sum_upper: assert property (rd_in && addr_in == ASM_SUMMARY_ADDR |=> rdata_out[7:1] == 7'h00)
    else $error("summary upper bits set");
  chk_pll_set: assert property (!pll_locked_in ##1 rd_flags |=> rdata_out[4])
    else $error("pll flag missing");
  chk_clk_set: assert property (divider_mismatch_in ##1 rd_flags |=> rdata_out[0])
    else $error("clock flag missing");
  chk_realign_set: assert property (sysref_realign_in ##1 rd_flags |=> rdata_out[2])
    else $error("realign flag missing");
  chk_pll_clear: assert property (wr_in && addr_in == ASM_FLAGS_ADDR && wdata_in[4] && pll_locked_in ##1
    rd_flags && pll_locked_in |=> !rdata_out[4]) else $error("pll flag not cleared");
  chk_pin_route: assert property ($past(rst_ok) |->
    status_output_pin_out == ($past(sel_q) ? irq_out : $past(cal_status_in))) else $error("pin mismatch");
  chk_irq_masked: assert property ($past(rst_ok) && ($past(mask_q) | 8'hC2) == 8'hFF |-> !irq_out)
    else $error("irq while all masked");
  chk_irq_pll: assert property (!pll_locked_in && !mask_q[4] ##1 !mask_q[4] |=> irq_out)
    else $error("irq missing");
endmodule

bind asm_alarm_top asm_alarm_checker u_asm_alarm_checker (
  .clk_in, .rst_n_in, .soft_reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .pll_locked_in,
  .sysref_realign_in, .divider_mismatch_in, .cal_status_in, .status_output_pin_out, .irq_out
);

// ### dv/tb_asm_alarm_top.sv
// testbench: directed tests of the alarm aggregator
`timescale 1ns/1ps
module tb_asm_alarm_top;
  import asm_pkg::*;
  // ****
  // signals
  // ****
  logic        clk_in = 1'b0, rst_n_in = 1'b0, soft_reset_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [11:0] addr_in = 12'h000;
  logic [7:0]  wdata_in = 8'h00, lane_active_in = 8'hFF, lane_fifo_err_in = 8'h00, rdata_out;
  logic        pll_locked_in = 1'b1, data_encoding_state_in = 1'b1, realign_in = 1'b0;
  logic        sysref_realign_in = 1'b0, divider_mismatch_in = 1'b0, cal_status_in = 1'b0;
  logic        status_output_pin_out, irq_out, serial_link_enable_out;
  int          error_cnt = 0, checked = 0, cycles = 0;
  logic [7:0]  mv [4] = '{8'h2F, 8'h1F, 8'h0F, 8'h3F};
  logic        sv [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  int          evl [5] = '{0, 2, 3, 4, 5};
  asm_alarm_top u_asm_alarm_top (
    .clk_in, .rst_n_in, .soft_reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .lane_active_in,
    .lane_fifo_err_in, .pll_locked_in, .data_encoding_state_in, .realign_in, .sysref_realign_in,
    .divider_mismatch_in, .cal_status_in, .status_output_pin_out, .irq_out, .serial_link_enable_out
  );
  always #2 clk_in = ~clk_in;
  // the run is about 80 cycles; the ceiling only catches a hang
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  // ****
  // tasks
  // ****
  task automatic stop_test();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk_reg({7'h00, got}, {7'h00, exp});
  endtask
  // every strobe is assigned once per call, so calls may follow back to back
  task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    #1;
    if (r)
      chk_reg(rdata_out, d);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, e);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 12'h000, 8'h00);
  endtask
  task automatic ev(input int i, input logic on);
    case (i)
      0: divider_mismatch_in <= on;
      2: sysref_realign_in <= on;
      3: data_encoding_state_in <= !on;
      4: pll_locked_in <= !on;
      default: lane_fifo_err_in <= on ? 8'h04 : 8'h00;
    endcase
  endtask
  // ****
  // scenarios
  // ****
  task automatic test_reset_values();
    rd(ASM_FLAGS_ADDR, 8'h3F);
    rd(ASM_MASK_ADDR, 8'h3F);
    rd(12'h2C3, 8'h00);
    chk_pin(serial_link_enable_out, 1'b0);
    chk_pin(irq_out, 1'b0);
    $display("reset test done");
  endtask
  task automatic test_clear();
    wr(ASM_FLAGS_ADDR, 8'h3F);
    rd(ASM_FLAGS_ADDR, 8'h00);
    rd(ASM_LANE_ADDR, 8'h00);
    ev(0, 1'b1);
    wr(ASM_FLAGS_ADDR, 8'h01);
    ev(0, 1'b0);
    wr(ASM_FLAGS_ADDR, 8'h00);
    rd(ASM_FLAGS_ADDR, 8'h01);
    wr(ASM_FLAGS_ADDR, 8'h01);
    rd(ASM_FLAGS_ADDR, 8'h00);
    $display("clear test done");
  endtask
  // link off and an inactive lane: neither the link nor the fifo flag may rise
  task automatic test_gating();
    ev(3, 1'b1);
    realign_in <= 1'b1;
    lane_active_in <= 8'hFB;
    ev(5, 1'b1);
    idle(1);
    ev(3, 1'b0);
    ev(5, 1'b0);
    realign_in <= 1'b0;
    lane_active_in <= 8'hFF;
    rd(ASM_FLAGS_ADDR, 8'h00);
    rd(ASM_LANE_ADDR, 8'h00);
    $display("gating test done");
  endtask
  task automatic test_events();
    wr(ASM_CTRL_ADDR, 8'h01);
    chk_pin(serial_link_enable_out, 1'b1);
    foreach (evl[k])
    begin
      wr(ASM_FLAGS_ADDR, 8'h3F);
      ev(evl[k], 1'b1);
      idle(1);
      ev(evl[k], 1'b0);
      rd(ASM_FLAGS_ADDR, 8'h01 << evl[k]);
    end
    rd(ASM_LANE_ADDR, 8'h04);
    wr(ASM_FLAGS_ADDR, 8'h20);
    rd(ASM_LANE_ADDR, 8'h00);
    realign_in <= 1'b1;
    idle(1);
    realign_in <= 1'b0;
    rd(ASM_FLAGS_ADDR, 8'h00);
    wr(ASM_CTRL_ADDR, 8'h02);
    wr(ASM_FLAGS_ADDR, 8'h3F);
    wr(ASM_CTRL_ADDR, 8'h03);
    idle(2);
    rd(ASM_FLAGS_ADDR, 8'h08);
    wr(ASM_FLAGS_ADDR, 8'h08);
    realign_in <= 1'b1;
    idle(1);
    realign_in <= 1'b0;
    rd(ASM_FLAGS_ADDR, 8'h08);
    $display("event test done");
  endtask
  task automatic test_mask_irq();
    wr(ASM_CTRL_ADDR, 8'h01);
    wr(ASM_FLAGS_ADDR, 8'h3F);
    wr(ASM_MASK_ADDR, 8'h2F);
    ev(4, 1'b1);
    ev(5, 1'b1);
    idle(1);
    ev(4, 1'b0);
    ev(5, 1'b0);
    foreach (mv[k])
    begin
      wr(ASM_MASK_ADDR, mv[k]);
      idle(1);
      chk_pin(irq_out, sv[k]);
      rd(ASM_SUMMARY_ADDR, {7'h00, sv[k]});
    end
    wr(ASM_MASK_ADDR, 8'h2F);
    wr(ASM_CTRL_ADDR, 8'h05);
    idle(1);
    chk_pin(status_output_pin_out, 1'b1);
    wr(ASM_CTRL_ADDR, 8'h01);
    idle(1);
    chk_pin(status_output_pin_out, 1'b0);
    cal_status_in <= 1'b1;
    idle(1);
    chk_pin(status_output_pin_out, 1'b1);
    cal_status_in <= 1'b0;
    wr(ASM_FLAGS_ADDR, 8'h10);
    idle(1);
    chk_pin(irq_out, 1'b0);
    wr(ASM_SUMMARY_ADDR, 8'hFF);
    rd(ASM_SUMMARY_ADDR, 8'h00);
    $display("irq test done");
  endtask
  task automatic test_soft_reset();
    soft_reset_in <= 1'b1;
    idle(1);
    soft_reset_in <= 1'b0;
    rd(ASM_FLAGS_ADDR, 8'h3F);
    rd(ASM_MASK_ADDR, 8'h3F);
    chk_pin(serial_link_enable_out, 1'b0);
    $display("soft reset test done");
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    test_reset_values();
    test_clear();
    test_gating();
    test_events();
    test_mask_irq();
    test_soft_reset();
    stop_test();
  end
endmodule

// ### hw/asm_alarm_top.sv
// module: alarm flag, mask and summary aggregator with register port and interrupt pin
`timescale 1ns/1ps
module asm_alarm_top
  import asm_pkg::*;
#(
  parameter int LANES = ASM_LANES
)
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  soft_reset_in,
  input  wire logic [ASM_ADDR_W-1:0] addr_in,
  input  wire logic [ASM_DATA_W-1:0] wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [ASM_DATA_W-1:0] rdata_out,
  input  wire logic [LANES-1:0]      lane_active_in,
  input  wire logic [LANES-1:0]      lane_fifo_err_in,
  input  wire logic                  pll_locked_in,
  input  wire logic                  data_encoding_state_in,
  input  wire logic                  realign_in,
  input  wire logic                  sysref_realign_in,
  input  wire logic                  divider_mismatch_in,
  input  wire logic                  cal_status_in,
  output logic                       status_output_pin_out,
  output logic                       irq_out,
  output logic                       serial_link_enable_out
);
  // ****************************************************************
  // state and parameter checks
  // ****************************************************************
  typedef struct packed
  {
    logic [7:0] mask;
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic       pin;
    logic       irq;
  } asm_top_state_t;

  asm_top_state_t st_q;
  asm_top_state_t st_d;

  // refused at elaboration: lane flags share one eight-bit register
  if (LANES < 1 || LANES > ASM_DATA_W)
  begin
    $error("lane count must be 1 to 8");
  end

  // ****************************************************************
  // decode
  // ****************************************************************
  function automatic logic hit(input logic [ASM_ADDR_W-1:0] a, input logic [11:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  logic             rst_all_n;
  logic             wr_flags;
  logic             wr_mask;
  logic             wr_lane;
  logic             wr_ctrl;
  logic [7:0]       flag_set;
  logic [7:0]       flag_clr;
  logic [7:0]       flags;
  logic [LANES-1:0] lane_set;
  logic [LANES-1:0] lane_clr;
  logic [LANES-1:0] lane_flags;
  logic             link_en;
  logic             mode66;
  logic             link_en_rise;
  logic             summary;
  logic [7:0]       lane_word;

  // soft reset acts as a full block reset, same presets as power-on
  assign rst_all_n = rst_n_in & ~soft_reset_in;
  assign wr_flags  = wr_in & hit(addr_in, ASM_FLAGS_ADDR);
  assign wr_mask   = wr_in & hit(addr_in, ASM_MASK_ADDR);
  assign wr_lane   = wr_in & hit(addr_in, ASM_LANE_ADDR);
  assign wr_ctrl   = wr_in & hit(addr_in, ASM_CTRL_ADDR);
  assign link_en   = st_q.ctrl[ASM_CTRL_LINK_EN];
  assign mode66    = st_q.ctrl[ASM_CTRL_MODE66];

  asm_edge #(
    .WIDTH (1)
  ) u_link_start (
    .clk_in   (clk_in),
    .rst_n_in (rst_all_n),
    .level_in (link_en),
    .rise_out (link_en_rise)
  );

  // ****************************************************************
  // flag set conditions
  // ****************************************************************
  // undefined flags while the link is off are simply held at their last value
  always_comb
  begin
    flag_set                  = ASM_ZERO;
    flag_set[ASM_BIT_FIFO]    = |(lane_active_in & lane_fifo_err_in);
    flag_set[ASM_BIT_PLL]     = ~pll_locked_in;
    if (mode66)
      flag_set[ASM_BIT_LINK]  = link_en & (link_en_rise | realign_in);
    else
      flag_set[ASM_BIT_LINK]  = link_en & ~data_encoding_state_in;
    flag_set[ASM_BIT_REALIGN] = sysref_realign_in;
    flag_set[ASM_BIT_CLK]     = divider_mismatch_in;
  end

  assign flag_clr = wr_flags ? (wdata_in & ASM_FLAGS_IMPL) : ASM_ZERO;
  assign lane_set = lane_active_in & lane_fifo_err_in;
  // a fifo flag clear wipes every lane bit too
  assign lane_clr = (wr_flags & wdata_in[ASM_BIT_FIFO]) ? {LANES{1'b1}}
                  : (wr_lane ? wdata_in[LANES-1:0] : {LANES{1'b0}});

  asm_sticky #(
    .WIDTH (8),
    .RST   (ASM_FLAGS_RST)
  ) u_flags (
    .clk_in    (clk_in),
    .rst_n_in  (rst_all_n),
    .set_in    (flag_set),
    .clr_in    (flag_clr),
    .flags_out (flags)
  );

  asm_sticky #(
    .WIDTH (LANES),
    .RST   (ASM_LANE_RST)
  ) u_lanes (
    .clk_in    (clk_in),
    .rst_n_in  (rst_all_n),
    .set_in    (lane_set),
    .clr_in    (lane_clr),
    .flags_out (lane_flags)
  );

  // ****************************************************************
  // summary
  // ****************************************************************
  // reserved bit 1 is set at reset but never reaches the summary
  assign summary = |(flags & ~st_q.mask & ASM_FLAGS_IMPL & ~(8'h01 << ASM_BIT_RSV1));

  always_comb
  begin
    lane_word               = ASM_ZERO;
    lane_word[LANES-1:0]    = lane_flags;
  end

  // ****************************************************************
  // registers and read port
  // ****************************************************************
  always_comb
  begin
    st_d       = st_q;
    st_d.rdata = ASM_ZERO;
    // mask 7:6 are stored as written; software is expected to keep them zero
    if (wr_mask)
      st_d.mask = wdata_in;
    if (wr_ctrl)
      st_d.ctrl = wdata_in & ASM_CTRL_IMPL;
    if (rd_in)
    begin
      if (hit(addr_in, ASM_SUMMARY_ADDR))
        st_d.rdata = {7'h00, summary};
      else if (hit(addr_in, ASM_FLAGS_ADDR))
        st_d.rdata = flags & ASM_FLAGS_IMPL;
      else if (hit(addr_in, ASM_MASK_ADDR))
        st_d.rdata = st_q.mask;
      else if (hit(addr_in, ASM_LANE_ADDR))
        st_d.rdata = lane_word;
      else if (hit(addr_in, ASM_CTRL_ADDR))
        st_d.rdata = st_q.ctrl;
      else
        st_d.rdata = ASM_ZERO;
    end
    st_d.irq = summary;
    // pin select: summary as hardware interrupt, else calibration status
    st_d.pin = st_q.ctrl[ASM_CTRL_PIN_SEL] ? summary : cal_status_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_all_n)
    begin
      st_q.mask  <= ASM_MASK_RST;
      st_q.ctrl  <= ASM_CTRL_RST;
      st_q.rdata <= ASM_ZERO;
      st_q.pin   <= 1'b0;
      st_q.irq   <= 1'b0;
    end
    else
      st_q <= st_d;
  end

  assign rdata_out              = st_q.rdata;
  assign status_output_pin_out  = st_q.pin;
  assign irq_out                = st_q.irq;
  assign serial_link_enable_out = st_q.ctrl[ASM_CTRL_LINK_EN];
endmodule

// ### hw/asm_edge.sv
// module: rising-edge pulse detector for the link enable bit
`timescale 1ns/1ps
module asm_edge
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] rise_out
);
  typedef struct packed
  {
    logic [WIDTH-1:0] prev;
  } asm_edge_state_t;

  asm_edge_state_t st_q;
  asm_edge_state_t st_d;

  if (WIDTH < 1)
  begin
    $error("asm_edge width must be positive");
  end

  always_comb
  begin
    st_d.prev = level_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      st_q.prev <= '0;
    else
      st_q <= st_d;
  end

  assign rise_out = level_in & ~st_q.prev;
endmodule

// ### hw/asm_pkg.sv
// package: register map, field positions, reset values and modes of the alarm aggregator
package asm_pkg;
  localparam int          ASM_ADDR_W        = 12;
  localparam int          ASM_DATA_W        = 8;
  localparam int          ASM_LANES         = 8;
  // register addresses
  localparam logic [11:0] ASM_SUMMARY_ADDR  = 12'h2C0;
  localparam logic [11:0] ASM_FLAGS_ADDR    = 12'h2C1;
  localparam logic [11:0] ASM_MASK_ADDR     = 12'h2C2;
  localparam logic [11:0] ASM_LANE_ADDR     = 12'h2C4;
  localparam logic [11:0] ASM_CTRL_ADDR     = 12'h2C8;
  // flag / mask bit positions
  localparam int          ASM_BIT_CLK       = 0;
  localparam int          ASM_BIT_RSV1      = 1;
  localparam int          ASM_BIT_REALIGN   = 2;
  localparam int          ASM_BIT_LINK      = 3;
  localparam int          ASM_BIT_PLL       = 4;
  localparam int          ASM_BIT_FIFO      = 5;
  localparam int          ASM_BIT_SUMMARY   = 0;
  // control register fields
  localparam int          ASM_CTRL_LINK_EN  = 0;
  localparam int          ASM_CTRL_MODE66   = 1;
  localparam int          ASM_CTRL_PIN_SEL  = 2;
  // reset values and implemented bit masks
  localparam logic [7:0]  ASM_FLAGS_RST     = 8'h3F;
  localparam logic [7:0]  ASM_MASK_RST      = 8'h3F;
  localparam logic [7:0]  ASM_LANE_RST      = 8'hFF;
  localparam logic [7:0]  ASM_CTRL_RST      = 8'h00;
  localparam logic [7:0]  ASM_FLAGS_IMPL    = 8'h3F;
  localparam logic [7:0]  ASM_CTRL_IMPL     = 8'h07;
  localparam logic [7:0]  ASM_ZERO          = 8'h00;
endpackage

// ### hw/asm_sticky.sv
// module: generic bank of sticky set-wins-over-clear flags with reset preset
`timescale 1ns/1ps
module asm_sticky
  import asm_pkg::*;
#(
  parameter int         WIDTH = 8,
  parameter logic [7:0] RST   = 8'hFF
)
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  output logic      [WIDTH-1:0] flags_out
);
  typedef struct packed
  {
    logic [WIDTH-1:0] flags;
  } asm_sticky_state_t;

  asm_sticky_state_t st_q;
  asm_sticky_state_t st_d;

  // refused at elaboration: the reset preset is only eight bits wide
  if (WIDTH < 1 || WIDTH > 8)
  begin
    $error("asm_sticky width out of range");
  end

  // set wins over clear so a live event is never lost
  always_comb
  begin
    st_d = st_q;
    for (int i = 0; i < WIDTH; i++)
    begin
      st_d.flags[i] = set_in[i] | (st_q.flags[i] & ~clr_in[i]);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      st_q.flags <= RST[WIDTH-1:0];
    else
      st_q <= st_d;
  end

  assign flags_out = st_q.flags;
endmodule
